/* sim/psc_loader_test.sv */
// Self-checking bench for the strap configuration loader
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_loader_test;
   import psc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, host_rxd_oe, config_done, disturb;
   logic autoneg_strap, fde_strap, cfg_strap_a, cfg_strap_b, cfg_strap_c;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] host_txd, core_rxd, core_txd, host_rxd;
   logic [4:0] addr_strap, led_out, phy_addr;
   logic [9:0] setting;
   psc_host_mode_t host_mode;
   int err_total, checks, cyc;
   // Strap sets: {addr, c, b, a, fde, autoneg}
   logic [9:0] cfg_tab [11] = '{10'h00a, 10'h3e4, 10'h149, 10'h2ab, 10'h025, 10'h207,
                                10'h06d, 10'h3cf, 10'h093, 10'h018, 10'h11d};

   // ****************************************************************
   // Design and board
   // ****************************************************************
   psc_loader dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .autoneg_strap, .fde_strap, .cfg_strap_a, .cfg_strap_b, .cfg_strap_c, .addr_strap,
      .host_txd, .core_rxd, .core_txd, .host_rxd, .host_rxd_oe, .led_out, .phy_addr, .host_mode,
      .config_done);
   psc_strap_board board_u (.setting, .disturb, .autoneg_strap, .fde_strap, .cfg_strap_a,
      .cfg_strap_b, .cfg_strap_c, .addr_strap);

   // ****************************************************************
   // Clock, timeout and shared tasks
   // ****************************************************************
   always #20 pclk = ~pclk;

   // A hung handshake must still reach the verdict
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         conclude();
      end
   end

   task conclude();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Request held until pready is seen at a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
            output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No local limit: a slave that never answers is caught by the bench timeout
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk($sformatf("reg %h", a), q, exp);
      chk("pslverr", 32'(e), 32'h0);
   endtask : rd

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task hp(input logic iso, input logic [3:0] d);
      @(posedge pclk);
      host_txd <= d;
      core_rxd <= ~d;
      repeat (2) @(posedge pclk);
      chk("core_txd", 32'(core_txd), iso ? 32'h0 : 32'(d));
      chk("host_rxd", 32'(host_rxd), iso ? 32'h0 : {28'h0, ~d});
      chk("host_rxd_oe", 32'(host_rxd_oe), 32'(!iso));
   endtask : hp

   // ****************************************************************
   // One strap set: reset, load, register checks, software takeover
   // ****************************************************************
   task run_cfg(input logic [9:0] s, input logic [3:0] k);
      logic an, fd, a, b, c, mii;
      logic [4:0] ad;
      logic [3:0] adv;
      logic [31:0] q;
      logic e;
      psc_host_mode_t hm;
      int n;
      {ad, c, b, a, fd, an} = s;
      mii = !(c && !a);
      adv = (an && mii) ? {a & fd, a, b & fd, b} : `PSC_ADV_ALL;
      hm = mii ? PSC_HM_MII : (b ? PSC_HM_RMII : PSC_HM_SMII);
      setting <= s;
      disturb <= 1'b0;
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      chk("done_in_reset", 32'(config_done), 32'h0);
      presetn <= 1'b1;
      n = 0;
      while (config_done !== 1'b1 && n < 10)
      begin
         @(posedge pclk);
         n++;
      end
      // Pins move once loaded; nothing may follow them
      disturb <= 1'b1;
      chk("config_done", 32'(config_done), 32'h1);
      rd(`PSC_OFS_CTRL, {16'h0, 1'b0, !an && mii && b, 1'b0, an, 1'b0, ad == 5'h00, 1'b0, !an && fd, 8'h0});
      rd(`PSC_OFS_ADV, {23'h0, adv, 5'h01});
      rd(`PSC_OFS_TX100, 32'h01c0 | {30'h0, !an && !c && a, 1'b0});
      rd(`PSC_OFS_FIFO, {19'h0, c && !a && !b, c && !a && b, 11'h0});
      rd(`PSC_OFS_STRAP, {22'h0, s});
      chk("phy_addr", 32'(phy_addr), 32'(ad));
      chk("host_mode", 32'(host_mode), 32'(hm));
      chk("led_idle", 32'(led_out), 32'(ad));
      hp(ad == 5'h00, k);
      wr(`PSC_OFS_LED, 32'h1f);
      repeat (2) @(posedge pclk);
      chk("led_lit", 32'(led_out), {27'h0, ~ad});
      wr(`PSC_OFS_CTRL, 32'h0100);
      rd(`PSC_OFS_CTRL, {19'h0, an, 12'h100});
      hp(1'b0, ~k);
      // Software owns ADV and TX100; the FIFO mode bits and the status copy stay read-only
      wr(`PSC_OFS_ADV, 32'h5a5a);
      rd(`PSC_OFS_ADV, 32'h5a5a);
      wr(`PSC_OFS_TX100, 32'ha5a5);
      rd(`PSC_OFS_TX100, 32'ha5a5);
      wr(`PSC_OFS_FIFO, 32'hffff);
      rd(`PSC_OFS_FIFO, {19'h0, c && !a && !b, c && !a && b, 11'h0});
      wr(`PSC_OFS_STRAP, 32'h0);
      rd(`PSC_OFS_STRAP, {22'h0, s});
      chk("phy_addr_held", 32'(phy_addr), 32'(ad));
      apb(1'b0, 8'h18, 32'h0, q, e);
      chk("unmapped_err", 32'(e), 32'h1);
      chk("unmapped_data", q, 32'h0);
      $display("strap set %0d done", k);
   endtask : run_cfg

   // Every input gets a level at time zero
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      host_txd = 4'h0;
      core_rxd = 4'h0;
      setting = 10'h000;
      disturb = 1'b0;
      foreach (cfg_tab[i])
         run_cfg(cfg_tab[i], 4'(i + 1));
      conclude();
   end
endmodule : psc_loader_test

/* sim/psc_strap_board.sv */
// Board strap resistor model facing the strap loader pins
`timescale 1ns/1ps

module psc_strap_board
(
   input wire logic [9:0] setting,
   input wire logic disturb,
   output logic autoneg_strap,
   output logic fde_strap,
   output logic cfg_strap_a,
   output logic cfg_strap_b,
   output logic cfg_strap_c,
   output logic [4:0] addr_strap
);
   // ****************************************************************
   // Pin levels
   // ****************************************************************
   wire logic [9:0] pin_lvl;

   // After loading, the shared pins carry other traffic, so show the inverse level
   assign pin_lvl = disturb ? ~setting : setting;
   // Same packing as the strap register: addr, c, b, a, fde, autoneg
   assign {addr_strap, cfg_strap_c, cfg_strap_b, cfg_strap_a, fde_strap, autoneg_strap} = pin_lvl;
endmodule : psc_strap_board

/* src/psc_led_drive.sv */
// LED output drivers with strap-selected polarity
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_led_drive
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [`PSC_LED_N-1:0] led_on,
   input wire logic [`PSC_LED_N-1:0] led_pol,
   output logic [`PSC_LED_N-1:0] led_out
);
   import psc_pkg::*;

   // A strap pulled high makes the LED sink, so it does not fight the pull
   genvar i;
   generate
      for (i = 0; i < `PSC_LED_N; i = i + 1)
      begin : g_led
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               led_out[i] <= 1'b0;
            else
               led_out[i] <= led_pol[i] ? ~led_on[i] : led_on[i]; // [R11] [R12]
         end
      end
   endgenerate

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_led_pol;
      @(posedge pclk) disable iff (!presetn)
         ##1 led_out == ($past(led_pol) ^ $past(led_on));
   endproperty
   a_led_pol: assert property (p_led_pol) else $error("LED polarity wrong"); // [R11] [R12]

endmodule : psc_led_drive

/* src/psc_loader.sv */
// Strap configuration loader with APB register access
// Function
// [R1] Autoneg on: fde and cfg pick FD advertisement; in SMII or RMII mode the code advertises 8:5 all ones
// [R2] Autoneg off: fde loads control duplex bit
// [R3] Straps give initial values; software owns afterwards
// [R4] Autoneg off, cfg_c low: cfg_a sets MLT-3
// [R5] Autoneg off, MII: cfg_b sets loopback
// [R6] Autoneg on, MII: straps set advertise 8:5
// [R7] cfg_c high, cfg_a low: SMII or RMII
// [R8] Autoneg off: advertise bits 8:5 all ones
// [R9] Autoneg on: MLT-3 on, loopback off
// [R10] Address straps sampled to fix LED polarity
// [R11] Address strap low: LED active high
// [R12] Address strap high: LED active low
// [R13] Address straps give five-bit PHY address
// [R14] Address zero sets isolate at reset
// [R15] Autoneg strap high forces enable, blocks writes
// [R16] Isolate tri-states host outputs, ignores inputs
// [R17] Straps latched once after reset release
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_loader
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic autoneg_strap,
   input wire logic fde_strap,
   input wire logic cfg_strap_a,
   input wire logic cfg_strap_b,
   input wire logic cfg_strap_c,
   input wire logic [4:0] addr_strap,
   input wire logic [3:0] host_txd,
   input wire logic [3:0] core_rxd,
   output logic [3:0] core_txd,
   output logic [3:0] host_rxd,
   output logic host_rxd_oe,
   output logic [4:0] led_out,
   output logic [4:0] phy_addr,
   output psc_pkg::psc_host_mode_t host_mode,
   output logic config_done
);
   import psc_pkg::*;

   // ****************************************************************
   // Strap capture
   // ****************************************************************
   logic [`PSC_STRAP_W-1:0] strap_q;
   logic load_pulse;
   logic loaded;

   psc_strap_latch u_latch
   (
      .pclk(pclk),
      .presetn(presetn),
      .strap_in({addr_strap, cfg_strap_c, cfg_strap_b, cfg_strap_a, fde_strap, autoneg_strap}),
      .strap_q(strap_q),
      .load_pulse(load_pulse),
      .loaded(loaded)
   );

   // Host interface choice; cfg_c high with cfg_a high falls back to MII
   function automatic psc_host_mode_t mode_of(input logic a, input logic b, input logic c);
      if (c && !a)
         mode_of = b ? PSC_HM_RMII : PSC_HM_SMII;
      else
         mode_of = PSC_HM_MII;
   endfunction : mode_of

   // Named fields of the latched straps
   wire s_an = strap_q[`PSC_ST_AN];
   wire s_fde = strap_q[`PSC_ST_FDE];
   wire s_a = strap_q[`PSC_ST_A];
   wire s_b = strap_q[`PSC_ST_B];
   wire s_c = strap_q[`PSC_ST_C];
   wire [4:0] s_addr = strap_q[`PSC_ST_ADDR_HI:`PSC_ST_ADDR_LO];
   wire psc_host_mode_t s_mode = mode_of(s_a, s_b, s_c); // [R7]
   wire s_mii = (s_mode == PSC_HM_MII);

   // ****************************************************************
   // Values loaded once from the straps
   // ****************************************************************
   // Speed abilities: cfg_b asks for 10 Mb/s, cfg_a for 100 Mb/s
   wire ab_10 = s_b;
   wire ab_100 = s_a;
   wire [3:0] adv_mii = {ab_100 & s_fde, ab_100, ab_10 & s_fde, ab_10}; // [R1] [R6]
   wire [3:0] adv_sel = (s_an && s_mii) ? adv_mii : `PSC_ADV_ALL; // [R8]
   wire fdx_bit = !s_an && s_fde; // [R2]
   wire loop_bit = !s_an && s_mii && s_b; // [R5] [R9]
   wire mlt3_dis = !s_an && !s_c && s_a; // [R4] [R9]
   wire iso_bit = (s_addr == `PSC_ISO_ADDR); // [R14]

   wire [15:0] ctrl_load = `PSC_CTRL_RST
      | ({15'h0000, s_an} << `PSC_CTRL_AN)
      | ({15'h0000, fdx_bit} << `PSC_CTRL_FDX)
      | ({15'h0000, loop_bit} << `PSC_CTRL_LOOP)
      | ({15'h0000, iso_bit} << `PSC_CTRL_ISO);
   wire [15:0] adv_load = (`PSC_ADV_RST & ~`PSC_ADV_FIELD) | ({12'h000, adv_sel} << `PSC_ADV_LO);
   wire [15:0] tx_load = (`PSC_TX100_RST & ~(16'h0001 << `PSC_TX100_MLT3_DIS))
      | ({15'h0000, mlt3_dis} << `PSC_TX100_MLT3_DIS);
   wire [15:0] fifo_load = ({15'h0000, s_mode == PSC_HM_SMII} << `PSC_FIFO_SMII)
      | ({15'h0000, s_mode == PSC_HM_RMII} << `PSC_FIFO_RMII);

   // ****************************************************************
   // APB decode
   // ****************************************************************
   logic [15:0] ctrl_reg;
   logic [15:0] adv_reg;
   logic [15:0] tx100_reg;
   logic [15:0] fifo_reg;
   logic [4:0] led_reg;

   wire setup = psel && !penable;
   wire access = psel && penable && pready;
   wire wr = access && pwrite;
   wire hit_ctrl = (paddr == `PSC_OFS_CTRL);
   wire hit_adv = (paddr == `PSC_OFS_ADV);
   wire hit_tx = (paddr == `PSC_OFS_TX100);
   wire hit_fifo = (paddr == `PSC_OFS_FIFO);
   wire hit_strap = (paddr == `PSC_OFS_STRAP);
   wire hit_led = (paddr == `PSC_OFS_LED);
   wire known = hit_ctrl | hit_adv | hit_tx | hit_fifo | hit_strap | hit_led;

   // Read mux; unmapped offsets read zero
   wire [31:0] rd_mux = hit_ctrl ? {16'h0000, ctrl_reg}
      : hit_adv ? {16'h0000, adv_reg}
      : hit_tx ? {16'h0000, tx100_reg}
      : hit_fifo ? {16'h0000, fifo_reg}
      : hit_strap ? {22'h000000, strap_q}
      : hit_led ? {27'h0000000, led_reg}
      : 32'h00000000;

   // Self-clearing bits are not stored; the strap pins the enable while high
   wire [15:0] ctrl_wmask = pwdata[15:0] & `PSC_CTRL_WMASK;
   wire [15:0] ctrl_wdat = s_an ? (ctrl_wmask | (16'h0001 << `PSC_CTRL_AN)) : ctrl_wmask; // [R15]

   // The strap load always wins, software edits only after it
   wire [15:0] ctrl_next = load_pulse ? ctrl_load : ((wr && hit_ctrl) ? ctrl_wdat : ctrl_reg); // [R3]
   wire [15:0] adv_next = load_pulse ? adv_load : ((wr && hit_adv) ? pwdata[15:0] : adv_reg); // [R3]
   wire [15:0] tx_next = load_pulse ? tx_load : ((wr && hit_tx) ? pwdata[15:0] : tx100_reg); // [R3]
   wire [15:0] fifo_next = load_pulse ? fifo_load : fifo_reg;
   wire [4:0] led_next = (wr && hit_led) ? pwdata[4:0] : led_reg;

   // Zero-wait slave: answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup;
         prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
         pslverr <= setup && !known;
      end
   end

   // Management registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= `PSC_CTRL_RST;
         adv_reg <= `PSC_ADV_RST;
         tx100_reg <= `PSC_TX100_RST;
         fifo_reg <= 16'h0000;
         led_reg <= 5'h00;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         adv_reg <= adv_next;
         tx100_reg <= tx_next;
         fifo_reg <= fifo_next;
         led_reg <= led_next;
      end
   end

   // ****************************************************************
   // Host interface isolation and status outputs
   // ****************************************************************
   wire iso = ctrl_reg[`PSC_CTRL_ISO];

   // Isolated: outputs released, inputs replaced by zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         host_rxd <= 4'h0;
         host_rxd_oe <= 1'b0;
         core_txd <= 4'h0;
         phy_addr <= 5'h00;
         host_mode <= PSC_HM_MII;
         config_done <= 1'b0;
      end
      else
      begin
         host_rxd <= iso ? 4'h0 : core_rxd; // [R16]
         host_rxd_oe <= !iso; // [R16]
         core_txd <= iso ? 4'h0 : host_txd; // [R16]
         phy_addr <= s_addr; // [R13]
         host_mode <= s_mode; // [R7]
         config_done <= loaded;
      end
   end

   // LED polarity follows the sampled address straps
   psc_led_drive u_led
   (
      .pclk(pclk),
      .presetn(presetn),
      .led_on(led_reg),
      .led_pol(s_addr), // [R10]
      .led_out(led_out)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_load_an_off;
      load_pulse && !s_an;
   endsequence

   sequence s_load_an_on;
      load_pulse && s_an;
   endsequence

   property p_fdx;
      s_load_an_off |=> ctrl_reg[`PSC_CTRL_FDX] == s_fde;
   endproperty
   a_fdx: assert property (p_fdx) else $error("duplex bit not from fde strap"); // [R2]

   property p_adv_all;
      s_load_an_off |=> adv_reg[`PSC_ADV_HI:`PSC_ADV_LO] == `PSC_ADV_ALL;
   endproperty
   a_adv_all: assert property (p_adv_all) else $error("advertise not all ones"); // [R8]

   property p_adv_mii;
      s_load_an_on ##0 s_mii |=> adv_reg[`PSC_ADV_HI:`PSC_ADV_LO] == {s_a & s_fde, s_a, s_b & s_fde, s_b};
   endproperty
   a_adv_mii: assert property (p_adv_mii) else $error("advertise from straps wrong"); // [R6] [R1]

   property p_mlt3;
      s_load_an_off ##0 !s_c |=> tx100_reg[`PSC_TX100_MLT3_DIS] == s_a;
   endproperty
   a_mlt3: assert property (p_mlt3) else $error("MLT-3 bit wrong"); // [R4]

   property p_loop;
      s_load_an_off ##0 s_mii |=> ctrl_reg[`PSC_CTRL_LOOP] == s_b;
   endproperty
   a_loop: assert property (p_loop) else $error("loopback bit wrong"); // [R5]

   property p_an_default;
      s_load_an_on |=> !tx100_reg[`PSC_TX100_MLT3_DIS] && !ctrl_reg[`PSC_CTRL_LOOP] && ctrl_reg[`PSC_CTRL_AN];
   endproperty
   a_an_default: assert property (p_an_default) else $error("autoneg defaults wrong"); // [R9]

   property p_mode;
      load_pulse |=> fifo_reg[`PSC_FIFO_SMII] == (mode_of(s_a, s_b, s_c) == PSC_HM_SMII)
         && fifo_reg[`PSC_FIFO_RMII] == (s_c && !s_a && s_b) ##1 host_mode == s_mode;
   endproperty
   a_mode: assert property (p_mode) else $error("host mode wrong"); // [R7]

   property p_iso_load;
      load_pulse |=> ctrl_reg[`PSC_CTRL_ISO] == (s_addr == `PSC_ISO_ADDR);
   endproperty
   a_iso_load: assert property (p_iso_load) else $error("isolate not loaded from address"); // [R14]

   property p_an_lock;
      loaded && s_an && wr && hit_ctrl && !load_pulse |=> ctrl_reg[`PSC_CTRL_AN];
   endproperty
   a_an_lock: assert property (p_an_lock) else $error("autoneg enable cleared by write"); // [R15]

   property p_sw_owns;
      wr && hit_adv && !load_pulse |=> adv_reg == $past(pwdata[15:0]);
   endproperty
   a_sw_owns: assert property (p_sw_owns) else $error("software write lost"); // [R3]

   property p_isolate;
      iso |=> !host_rxd_oe && core_txd == 4'h0 && host_rxd == 4'h0;
   endproperty
   a_isolate: assert property (p_isolate) else $error("isolate not honoured"); // [R16]

   property p_addr;
      loaded |=> phy_addr == s_addr;
   endproperty
   a_addr: assert property (p_addr) else $error("PHY address not from straps"); // [R13]

   property p_apb_ready;
      setup |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("APB ready timing wrong");

endmodule : psc_loader

/* src/psc_map.svh */
// Register offsets, field positions and reset values of the strap loader
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

// ****************************************************************
// Register byte offsets on the APB bus
// ****************************************************************
`define PSC_OFS_CTRL 8'h00
`define PSC_OFS_ADV 8'h04
`define PSC_OFS_TX100 8'h08
`define PSC_OFS_FIFO 8'h0c
`define PSC_OFS_STRAP 8'h10
`define PSC_OFS_LED 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define PSC_CTRL_LOOP 14
`define PSC_CTRL_AN 12
`define PSC_CTRL_ISO 10
`define PSC_CTRL_FDX 8
`define PSC_TX100_MLT3_DIS 1
`define PSC_FIFO_SMII 12
`define PSC_FIFO_RMII 11
`define PSC_ADV_LO 5
`define PSC_ADV_HI 8
`define PSC_ST_AN 0
`define PSC_ST_FDE 1
`define PSC_ST_A 2
`define PSC_ST_B 3
`define PSC_ST_C 4
`define PSC_ST_ADDR_LO 5
`define PSC_ST_ADDR_HI 9

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define PSC_STRAP_W 10
`define PSC_LED_N 5
`define PSC_CTRL_RST 16'h0000
`define PSC_CTRL_WMASK 16'h7d80
`define PSC_ADV_RST 16'h01e1
`define PSC_ADV_FIELD 16'h01e0
`define PSC_ADV_ALL 4'hf
`define PSC_TX100_RST 16'h01c0
`define PSC_ISO_ADDR 5'h00

`endif

/* src/psc_pkg.sv */
// Types shared by the strap loader modules
package psc_pkg;

   // Loader sequence, Gray coded along wait, take, run
   typedef enum logic [1:0]
   {
      PSC_LD_WAIT = 2'h0,
      PSC_LD_TAKE = 2'h1,
      PSC_LD_RUN = 2'h3
   } psc_ld_state_t;

   // Host interface selected by the configuration straps
   typedef enum logic [1:0]
   {
      PSC_HM_MII = 2'h0,
      PSC_HM_SMII = 2'h1,
      PSC_HM_RMII = 2'h2
   } psc_host_mode_t;

endpackage : psc_pkg

/* src/psc_strap_latch.sv */
// One-shot capture of the strap pins after reset release
`timescale 1ns/1ps
`include "psc_map.svh"

module psc_strap_latch
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [`PSC_STRAP_W-1:0] strap_in,
   output logic [`PSC_STRAP_W-1:0] strap_q,
   output logic load_pulse,
   output logic loaded
);
   import psc_pkg::*;

   psc_ld_state_t state_reg;
   psc_ld_state_t state_next;
   logic take;

   // Pins are caught by the second clock after release, never by the reset itself
   assign take = (state_reg == PSC_LD_TAKE);
   always_comb
   begin
      case (state_reg)
         PSC_LD_WAIT: state_next = PSC_LD_TAKE;
         PSC_LD_TAKE: state_next = PSC_LD_RUN;
         PSC_LD_RUN: state_next = PSC_LD_RUN;
         default: state_next = PSC_LD_WAIT;
      endcase
   end

   // Capture once; later pin changes from the shared LED drivers are ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= PSC_LD_WAIT;
         strap_q <= '0;
         load_pulse <= 1'b0;
         loaded <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (take)
            strap_q <= strap_in; // [R17] [R10] [R13]
         load_pulse <= take;
         loaded <= loaded | take;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_strap_hold;
      @(posedge pclk) disable iff (!presetn) loaded |=> $stable(strap_q);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap copy changed after load"); // [R17]

endmodule : psc_strap_latch
